// ### sfx_crosscheck.sv
// Safety enable settings and two-channel cross-check behind an AHB-Lite slave.
// Assumes a single clock domain; all pins except the async reset i_arst_n are synchronous to i_mclk.
// Function
// - Pending settings become active only when mode leaves value 95.
// - Bit 0 of each channel's torque-off word enables its torque-off path.
// - Brake control enabled per channel by writing value 1.
// - Brake control stays inactive unless both torque-off words equal and nonzero.
// - Stop-1 counts enabled in a channel when its delay exceeds zero.
// - Stop-1 stays inactive unless both torque-off words equal and nonzero.
// - All paired settings are compared crosswise; software writes identical values.
// - Control channel selects from a binary source; power channel from pulse enable terminal.
// - After a failsafe input change, dynamic compare waits for the tolerance time.
// - Tolerance times differing by one monitoring cycle still count as matching.
// - First commissioning accepts setting writes without a nondefault password.
// - Password entry resets to zero so the default password matches.
// - In commissioning mode pulses stay suppressed; torque-off selection is ignored.
//
// Chosen here: the address map and the AHB-Lite register port.
`include "sfx_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sfx_crosscheck
  import sfx_pkg::*;
#(
  parameter logic [15:0] SAFE_PWD = 16'h0000  // Password the entry is compared with
) (
  input  wire logic                  i_mclk,                  // Monitoring clock
  input  wire logic                  i_arst_n,                // Async reset, low active
  input  wire logic                  hsel,                    // AHB select
  input  wire logic [31:0]           haddr,                   // AHB address
  input  wire logic [1:0]            htrans,                  // AHB transfer type
  input  wire logic                  hwrite,                  // AHB write
  input  wire logic [2:0]            hsize,                   // AHB size
  input  wire logic [31:0]           hwdata,                  // AHB write data
  input  wire logic                  hready,                  // AHB bus ready
  output logic [31:0]                hrdata,                  // AHB read data
  output logic                       hreadyout,               // AHB slave ready
  output logic                       hresp,                   // AHB response
  input  wire logic [7:0]            i_binary_source,         // Selectable binary signals
  input  wire logic                  i_pulse_enable_terminal, // Power stage enable pin
  input  wire logic [`SFX_FDI_W-1:0] i_failsafe_input,        // Failsafe inputs
  output logic                       o_sto_cc,                // Control channel torque off
  output logic                       o_sto_pc,                // Power channel torque off
  output logic                       o_pulse_suppress,        // Pulses safely suppressed
  output logic                       o_sbc_armed,             // Brake control active
  output logic                       o_ss1_armed,             // Stop-1 active
  output logic [1:0]                 o_xchk_fault,            // Sticky faults cc/pc
  output logic                       o_irq                    // Level interrupt
);

  // ***************************************************
  // Decode helpers
  // ***************************************************
  function automatic logic pair_gate(input sfx_chan_t a, input sfx_chan_t b);
    pair_gate = (a.sto == b.sto) && (a.sto != 8'h00);
  endfunction

  function automatic logic tol_close(input logic [15:0] a, input logic [15:0] b);
    tol_close = (a >= b) ? ((a - b) <= `SFX_TOL_STEP) : ((b - a) <= `SFX_TOL_STEP);
  endfunction

  sfx_state_t st_q;
  sfx_state_t st_d;

  logic        commis;
  logic        gate;
  logic        sel_cc;
  logic        sel_pc;
  logic        stat_mis;
  logic        dyn_mis;
  logic        pwd_ok;
  logic        ph_wr;
  logic        ph_rd;
  logic        fdi_chg;
  logic [15:0] tol_max;
  logic [31:0] rd_mux;

  assign commis  = (st_q.mode == `SFX_MODE_COMMIS);
  assign gate    = pair_gate(st_q.act_cc, st_q.act_pc);
  // Torque off is selected by a low source bit or a low enable terminal
  assign sel_cc  = st_q.act_cc.sto[0] & ~i_binary_source[st_q.src];
  assign sel_pc  = st_q.act_pc.sto[0] & ~i_pulse_enable_terminal;
  assign stat_mis = (st_q.act_cc.sto != st_q.act_pc.sto)
                 || (st_q.act_cc.brk != st_q.act_pc.brk)
                 || (st_q.act_cc.ss1 != st_q.act_pc.ss1)
                 || !tol_close(st_q.act_cc.tol, st_q.act_pc.tol);
  // Dynamic data only compared outside commissioning and outside the changeover window
  assign dyn_mis = !commis && (st_q.susp == 16'h0000) && (sel_cc != sel_pc);
  assign pwd_ok  = (st_q.pwd == SAFE_PWD);
  assign ph_wr   = st_q.wr;
  assign ph_rd   = st_q.rd;
  assign fdi_chg = (i_failsafe_input != st_q.fdi_prev);
  assign tol_max = (st_q.act_cc.tol > st_q.act_pc.tol) ? st_q.act_cc.tol : st_q.act_pc.tol;

  // ***************************************************
  // Read mux
  // ***************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (st_q.addr == `SFX_OFS_MODE) begin
      rd_mux = {24'h00_0000, st_q.mode};
    end else if (st_q.addr == `SFX_OFS_PWD) begin
      rd_mux = {16'h0000, st_q.pwd};
    end else if (st_q.addr == `SFX_OFS_CC_STO) begin
      rd_mux = {24'h00_0000, st_q.pend_cc.sto};
    end else if (st_q.addr == `SFX_OFS_CC_BRK) begin
      rd_mux = {24'h00_0000, st_q.pend_cc.brk};
    end else if (st_q.addr == `SFX_OFS_CC_SS1) begin
      rd_mux = {16'h0000, st_q.pend_cc.ss1};
    end else if (st_q.addr == `SFX_OFS_CC_TOL) begin
      rd_mux = {16'h0000, st_q.pend_cc.tol};
    end else if (st_q.addr == `SFX_OFS_CC_SRC) begin
      rd_mux = {29'h0000_0000, st_q.src};
    end else if (st_q.addr == `SFX_OFS_PC_STO) begin
      rd_mux = {24'h00_0000, st_q.pend_pc.sto};
    end else if (st_q.addr == `SFX_OFS_PC_BRK) begin
      rd_mux = {24'h00_0000, st_q.pend_pc.brk};
    end else if (st_q.addr == `SFX_OFS_PC_SS1) begin
      rd_mux = {16'h0000, st_q.pend_pc.ss1};
    end else if (st_q.addr == `SFX_OFS_PC_TOL) begin
      rd_mux = {16'h0000, st_q.pend_pc.tol};
    end else if (st_q.addr == `SFX_OFS_STATUS) begin
      rd_mux = {29'h0000_0000, st_q.status};
    end else if (st_q.addr == `SFX_OFS_MASK) begin
      rd_mux = {29'h0000_0000, st_q.mask};
    end else if (st_q.addr == `SFX_OFS_STATE) begin
      rd_mux = {24'h00_0000, (st_q.susp != 16'h0000), commis, o_ss1_armed,
                o_sbc_armed, o_sto_pc, o_sto_cc, gate, pwd_ok};
    end
  end

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    st_d = st_q;
    // Address phase capture; zero wait states
    st_d.wr   = hsel && hready && htrans[1] && hwrite;
    st_d.rd   = hsel && hready && htrans[1] && !hwrite;
    st_d.addr = (hsel && hready && htrans[1]) ? {haddr[5:2], 2'b00} : st_q.addr;

    if (ph_wr) begin
      if (st_q.addr == `SFX_OFS_MODE) begin
        st_d.mode = hwdata[7:0];
        if (commis && (hwdata[7:0] != `SFX_MODE_COMMIS)) begin
          st_d.act_cc = st_q.pend_cc;
          st_d.act_pc = st_q.pend_pc;
        end
      end else if (st_q.addr == `SFX_OFS_PWD) begin
        st_d.pwd = hwdata[15:0];
      end else if (st_q.addr == `SFX_OFS_MASK) begin
        st_d.mask = hwdata[2:0];
      end else if (commis && pwd_ok) begin
        // Settings only take writes in commissioning with a matching password
        if (st_q.addr == `SFX_OFS_CC_STO) begin
          st_d.pend_cc.sto = hwdata[7:0];
        end else if (st_q.addr == `SFX_OFS_CC_BRK) begin
          st_d.pend_cc.brk = hwdata[7:0];
        end else if (st_q.addr == `SFX_OFS_CC_SS1) begin
          st_d.pend_cc.ss1 = hwdata[15:0];
        end else if (st_q.addr == `SFX_OFS_CC_TOL) begin
          st_d.pend_cc.tol = hwdata[15:0];
        end else if (st_q.addr == `SFX_OFS_CC_SRC) begin
          st_d.src = hwdata[2:0];
        end else if (st_q.addr == `SFX_OFS_PC_STO) begin
          st_d.pend_pc.sto = hwdata[7:0];
        end else if (st_q.addr == `SFX_OFS_PC_BRK) begin
          st_d.pend_pc.brk = hwdata[7:0];
        end else if (st_q.addr == `SFX_OFS_PC_SS1) begin
          st_d.pend_pc.ss1 = hwdata[15:0];
        end else if (st_q.addr == `SFX_OFS_PC_TOL) begin
          st_d.pend_pc.tol = hwdata[15:0];
        end
      end
    end

    // Changeover window: reload on any failsafe edge, else count down
    st_d.fdi_prev = i_failsafe_input;
    if (fdi_chg) begin
      st_d.susp = tol_max;
    end else if (st_q.susp != 16'h0000) begin
      st_d.susp = st_q.susp - 16'h0001;
    end

    // Read clears status; a new event in the same cycle wins
    if (ph_rd && (st_q.addr == `SFX_OFS_STATUS)) begin
      st_d.status = 3'h0;
    end
    if (stat_mis || dyn_mis) begin
      st_d.status[`SFX_ST_CC_FLT] = 1'b1;
      st_d.status[`SFX_ST_PC_FLT] = 1'b1;
    end
    if (ph_wr && (st_q.addr == `SFX_OFS_MODE) && commis && (hwdata[7:0] != `SFX_MODE_COMMIS)) begin
      st_d.status[`SFX_ST_APPLIED] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q     <= '0;
      st_q.pwd <= `SFX_PWD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign hrdata    = rd_mux;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Commissioning forces suppression so selection changes cannot bounce the drive
  assign o_sto_cc         = !commis && sel_cc;
  assign o_sto_pc         = !commis && sel_pc;
  assign o_pulse_suppress = commis || sel_cc || sel_pc;
  assign o_sbc_armed = gate && (st_q.act_cc.brk == `SFX_BRK_ON)
                    && (st_q.act_pc.brk == `SFX_BRK_ON);
  assign o_ss1_armed = gate && (st_q.act_cc.ss1 != 16'h0000)
                    && (st_q.act_pc.ss1 != 16'h0000);
  assign o_xchk_fault = st_q.status[1:0];
  assign o_irq        = |(st_q.status & st_q.mask);

  // ***************************************************
  // Checks
  // ***************************************************
  a_apply_on_exit: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!commis && $past(st_q.mode) == `SFX_MODE_COMMIS) |-> (st_q.act_cc == $past(st_q.pend_cc)))
    else $error("settings not applied on exit");
  a_sbc_gated: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_sbc_armed |-> (st_q.act_cc.sto == st_q.act_pc.sto) && (st_q.act_cc.sto != 8'h00))
    else $error("brake control active without torque off enable");
  a_ss1_gated: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_ss1_armed |-> (st_q.act_cc.sto == st_q.act_pc.sto) && (st_q.act_pc.sto != 8'h00)
                    && (st_q.act_cc.ss1 != 16'h0000) && (st_q.act_pc.ss1 != 16'h0000))
    else $error("stop-1 active without enable");
  a_commis_supp: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    commis |-> (o_pulse_suppress && !o_sto_cc && !o_sto_pc))
    else $error("pulses not suppressed in commissioning");
  a_fault_sticky: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_xchk_fault[0] && !(ph_rd && st_q.addr == `SFX_OFS_STATUS)) |=> o_xchk_fault[0])
    else $error("fault flag dropped");
  a_tol_slack: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((st_q.act_cc.sto == st_q.act_pc.sto) && (st_q.act_cc.brk == st_q.act_pc.brk)
     && (st_q.act_cc.ss1 == st_q.act_pc.ss1) && !dyn_mis && (st_q.status[0] == 1'b0)
     && ((st_q.act_cc.tol - st_q.act_pc.tol == 16'h0001) || (st_q.act_pc.tol - st_q.act_cc.tol == 16'h0001)))
    |=> (st_q.status[0] == 1'b0))
    else $error("one-cycle tolerance difference flagged");
  a_mis_flag: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (((st_q.act_cc.tol == st_q.act_pc.tol + 16'h0002) && (st_q.act_cc.tol >= 16'h0002))
     || ((st_q.act_pc.tol == st_q.act_cc.tol + 16'h0002) && (st_q.act_pc.tol >= 16'h0002))) |=> st_q.status[0])
    else $error("tolerance mismatch not flagged");
  a_fdi_window: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (fdi_chg && tol_max != 16'h0000) |=> (st_q.susp == $past(tol_max)))
    else $error("changeover window not started");
  a_first_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (ph_wr && commis && st_q.pwd == 16'h0000 && SAFE_PWD == 16'h0000 && st_q.addr == `SFX_OFS_CC_STO)
    |=> (st_q.pend_cc.sto == $past(hwdata[7:0])))
    else $error("first commissioning write refused");
  // Positive and negative checks: each enable path must really reach its output, not only stay gated
  a_apply_power: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!commis && $past(st_q.mode) == `SFX_MODE_COMMIS) |-> (st_q.act_pc == $past(st_q.pend_pc)))
    else $error("power channel settings not applied on exit");
  a_active_hold: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (commis || !$past(commis)) |-> ($stable(st_q.act_cc) && $stable(st_q.act_pc)))
    else $error("active settings changed outside an exit");
  a_cc_select: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!commis && st_q.act_cc.sto[0] && !i_binary_source[st_q.src]) |-> o_sto_cc)
    else $error("control channel select lost");
  a_pc_select: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!commis && st_q.act_pc.sto[0] && !i_pulse_enable_terminal) |-> o_sto_pc)
    else $error("power channel select lost");
  a_cc_disabled: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !st_q.act_cc.sto[0] |-> !o_sto_cc)
    else $error("control channel torque off while disabled");
  a_pc_disabled: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !st_q.act_pc.sto[0] |-> !o_sto_pc)
    else $error("power channel torque off while disabled");
  a_sbc_enable: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((st_q.act_cc.sto == st_q.act_pc.sto) && (st_q.act_cc.sto != 8'h00) && (st_q.act_cc.brk == `SFX_BRK_ON)
     && (st_q.act_pc.brk == `SFX_BRK_ON)) |-> o_sbc_armed)
    else $error("brake control not active when enabled");
  a_ss1_enable: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((st_q.act_cc.sto == st_q.act_pc.sto) && (st_q.act_cc.sto != 8'h00) && (st_q.act_cc.ss1 != 16'h0000)
     && (st_q.act_pc.ss1 != 16'h0000)) |-> o_ss1_armed)
    else $error("stop-1 not active when enabled");
  a_window_quiet: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((st_q.susp != 16'h0000) && !stat_mis && (st_q.status[1:0] == 2'b00)) |=> (st_q.status[1:0] == 2'b00))
    else $error("dynamic compare inside changeover window");
  a_window_count: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!fdi_chg && (st_q.susp != 16'h0000)) |=> (st_q.susp == $past(st_q.susp) - 16'h0001))
    else $error("changeover window not counting");
  a_dyn_flag: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!commis && (st_q.susp == 16'h0000) && (o_sto_cc != o_sto_pc)) |=> (st_q.status[1:0] == 2'b11))
    else $error("dynamic mismatch not flagged");
  a_pwd_refuse: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (ph_wr && (st_q.pwd != SAFE_PWD) && (st_q.addr == `SFX_OFS_CC_STO)) |=> $stable(st_q.pend_cc.sto))
    else $error("setting taken with wrong password");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((st_q.status[0] && st_q.mask[0]) |-> o_irq) and ((st_q.mask == 3'h0) |-> !o_irq))
    else $error("interrupt level wrong");
  a_bus_okay: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (hreadyout && !hresp))
    else $error("bus answer not zero-wait okay");

endmodule

`default_nettype wire

// ### sfx_params.svh
// Constants for the safety enable cross-check block.
// Included by the package and the design; definitions only.
`ifndef SFX_PARAMS_SVH
`define SFX_PARAMS_SVH

// ***************************************************
// Register byte offsets
// ***************************************************
`define SFX_OFS_MODE      6'h00
`define SFX_OFS_PWD       6'h04
`define SFX_OFS_CC_STO    6'h08
`define SFX_OFS_CC_BRK    6'h0c
`define SFX_OFS_CC_SS1    6'h10
`define SFX_OFS_CC_TOL    6'h14
`define SFX_OFS_CC_SRC    6'h18
`define SFX_OFS_PC_STO    6'h20
`define SFX_OFS_PC_BRK    6'h24
`define SFX_OFS_PC_SS1    6'h28
`define SFX_OFS_PC_TOL    6'h2c
`define SFX_OFS_STATUS    6'h30
`define SFX_OFS_MASK      6'h34
`define SFX_OFS_STATE     6'h38

// ***************************************************
// Values, fields and resets
// ***************************************************
`define SFX_MODE_COMMIS   8'h5f
`define SFX_BRK_ON        8'h01
`define SFX_PWD_RST       16'h0000
`define SFX_ST_CC_FLT     0
`define SFX_ST_PC_FLT     1
`define SFX_ST_APPLIED    2
`define SFX_FDI_W         4
`define SFX_TOL_STEP      16'h0001

`endif

// ### sfx_pkg.sv
// Types for the safety enable cross-check block.
// Relies on sfx_params.svh for widths.
`include "sfx_params.svh"

package sfx_pkg;

  typedef struct packed {
    logic [7:0]  sto;
    logic [7:0]  brk;
    logic [15:0] ss1;
    logic [15:0] tol;
  } sfx_chan_t;

  typedef struct packed {
    logic [7:0]             mode;
    logic [15:0]            pwd;
    sfx_chan_t              pend_cc;
    sfx_chan_t              pend_pc;
    sfx_chan_t              act_cc;
    sfx_chan_t              act_pc;
    logic [2:0]             src;
    logic [2:0]             status;
    logic [2:0]             mask;
    logic [5:0]             addr;
    logic                   wr;
    logic                   rd;
    logic [`SFX_FDI_W-1:0]  fdi_prev;
    logic [15:0]            susp;
  } sfx_state_t;

endpackage

// ### sfx_crosscheck_bench.sv
// Self-checking bench for the safety enable cross-check block.
// Assumes sfx_crosscheck, sfx_params.svh, one clock; the bench is the AHB-Lite master.
`include "sfx_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sfx_crosscheck_bench;

  // ****************************************
  // Signals
  // ****************************************
  logic                  i_mclk, i_arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  logic [1:0]            htrans, o_xchk_fault;
  logic [2:0]            hsize;
  logic [7:0]            i_binary_source, s0, s1, b0, b1;
  logic [15:0]           d0, d1, t0, t1;
  logic                  i_pulse_enable_terminal, o_sto_cc, o_sto_pc, o_pulse_suppress;
  logic                  o_sbc_armed, o_ss1_armed, o_irq;
  logic [`SFX_FDI_W-1:0] i_failsafe_input;
  logic [5:0]            zero_at_rst [7];
  integer                seed = 32'hab1a;
  int                    mismatches = 0;
  int                    num_checks = 0;

  sfx_crosscheck dut (
    .i_mclk, .i_arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .i_binary_source, .i_pulse_enable_terminal, .i_failsafe_input,
    .o_sto_cc, .o_sto_pc, .o_pulse_suppress, .o_sbc_armed, .o_ss1_armed, .o_xchk_fault, .o_irq
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    chk_reg({31'h0, got}, {31'h0, exp}, what);
  endtask

  // Entered just after a rising edge; leaves at the edge that ends the data phase
  task automatic ahb(input logic w, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    haddr  <= {26'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge i_mclk);
    while (hreadyout !== 1'b1) @(posedge i_mclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge i_mclk);
    while (hreadyout !== 1'b1) @(posedge i_mclk);
    rdv = hrdata;
    chk_pin(hresp, 1'b0, "bus response");
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] got;
    ahb(1'b0, a, 32'h0, got);
    chk_reg(got, exp, what);
  endtask

  function automatic logic gate_ok(input logic [7:0] a, input logic [7:0] b);
    return (a == b) && (a != 8'h00);
  endfunction

  // Tolerance pair may differ by one monitoring cycle, t1 is never below t0 here
  function automatic logic tol_bad(input logic [15:0] a, input logic [15:0] b);
    return (b - a) > `SFX_TOL_STEP;
  endfunction

  task automatic check_case(input logic [7:0] sc, sp, bc, bp, input logic [15:0] dc, dp, tc, tp);
    logic f;
    f = (sc != sp) || (bc != bp) || (dc != dp) || tol_bad(tc, tp);
    wr(`SFX_OFS_MODE, {24'h0, `SFX_MODE_COMMIS});
    wr(`SFX_OFS_CC_STO, {24'h0, sc});
    wr(`SFX_OFS_PC_STO, {24'h0, sp});
    wr(`SFX_OFS_CC_BRK, {24'h0, bc});
    wr(`SFX_OFS_PC_BRK, {24'h0, bp});
    wr(`SFX_OFS_CC_SS1, {16'h0, dc});
    wr(`SFX_OFS_PC_SS1, {16'h0, dp});
    wr(`SFX_OFS_CC_TOL, {16'h0, tc});
    wr(`SFX_OFS_PC_TOL, {16'h0, tp});
    wr(`SFX_OFS_CC_SRC, 32'h3);
    wr(`SFX_OFS_MODE, 32'h0);
    repeat (3) @(posedge i_mclk);
    chk_pin(o_sbc_armed, gate_ok(sc, sp) && bc == `SFX_BRK_ON && bp == `SFX_BRK_ON, "brake");
    chk_pin(o_ss1_armed, gate_ok(sc, sp) && dc != 16'h0 && dp != 16'h0, "stop1");
    ahb(1'b0, `SFX_OFS_STATUS, 32'h0, rd);
    chk_reg(rd & 32'h4, 32'h4, "applied flag");
    rdchk(`SFX_OFS_STATUS, {29'h0, 1'b0, f, f}, "cross fault");
    repeat (2) @(posedge i_mclk);
    chk_pin(o_irq, f, "irq level");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    i_arst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    i_binary_source = 8'hff;
    i_pulse_enable_terminal = 1'b1;
    i_failsafe_input = '0;
    zero_at_rst = '{`SFX_OFS_MODE, `SFX_OFS_PWD, `SFX_OFS_CC_STO, `SFX_OFS_PC_TOL,
                    `SFX_OFS_STATUS, `SFX_OFS_MASK, 6'h3c};
    repeat (12) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    foreach (zero_at_rst[i]) rdchk(zero_at_rst[i], 32'h0, "reset value");
    rdchk(`SFX_OFS_STATE, 32'h1, "state after reset");
    wr(`SFX_OFS_MASK, 32'h7);
    wr(`SFX_OFS_MODE, {24'h0, `SFX_MODE_COMMIS});
    wr(`SFX_OFS_CC_STO, 32'h1);
    rdchk(`SFX_OFS_CC_STO, 32'h1, "default password write");
    wr(`SFX_OFS_PWD, 32'h1234);
    wr(`SFX_OFS_CC_STO, 32'h0);
    rdchk(`SFX_OFS_CC_STO, 32'h1, "wrong password refused");
    wr(`SFX_OFS_PWD, {16'h0, `SFX_PWD_RST});
    wr(`SFX_OFS_MODE, 32'h0);
    check_case(8'h1, 8'h1, 8'h1, 8'h1, 16'h10, 16'h10, 16'h5, 16'h6);
    // Both selects drop together, as grouped identically in both channels
    i_binary_source[3] <= 1'b0;
    i_pulse_enable_terminal <= 1'b0;
    i_failsafe_input <= i_failsafe_input + 1'b1;
    repeat (3) @(posedge i_mclk);
    chk_pin(o_sto_cc, 1'b1, "cc torque off");
    chk_pin(o_sto_pc, 1'b1, "pc torque off");
    chk_pin(o_pulse_suppress, 1'b1, "suppress");
    // Channel skew of two cycles stays inside the changeover window
    i_binary_source[3] <= 1'b1;
    i_failsafe_input <= i_failsafe_input + 1'b1;
    repeat (2) @(posedge i_mclk);
    i_pulse_enable_terminal <= 1'b1;
    repeat (12) @(posedge i_mclk);
    rdchk(`SFX_OFS_STATUS, 32'h0, "skew in window");
    // A four-cycle skew with no failsafe change is a fault, and it sticks
    i_pulse_enable_terminal <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_pulse_enable_terminal <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk_reg({30'h0, o_xchk_fault}, 32'h3, "sticky fault");
    chk_pin(o_irq, 1'b1, "irq raised");
    wr(`SFX_OFS_MASK, 32'h0);
    @(posedge i_mclk);
    chk_pin(o_irq, 1'b0, "irq masked");
    rdchk(`SFX_OFS_STATUS, 32'h3, "status set");
    rdchk(`SFX_OFS_STATUS, 32'h0, "status cleared");
    wr(`SFX_OFS_MASK, 32'h7);
    // Commissioning: selects ignored, pending brake change not yet active
    i_binary_source[3] <= 1'b0;
    i_pulse_enable_terminal <= 1'b0;
    i_failsafe_input <= i_failsafe_input + 1'b1;
    wr(`SFX_OFS_MODE, {24'h0, `SFX_MODE_COMMIS});
    wr(`SFX_OFS_CC_BRK, 32'h0);
    wr(`SFX_OFS_PC_BRK, 32'h0);
    chk_pin(o_sto_cc, 1'b0, "cc select ignored");
    chk_pin(o_sto_pc, 1'b0, "pc select ignored");
    chk_pin(o_pulse_suppress, 1'b1, "suppressed in commissioning");
    chk_pin(o_sbc_armed, 1'b1, "brake held until exit");
    rdchk(`SFX_OFS_CC_BRK, 32'h0, "pending readback");
    i_binary_source[3] <= 1'b1;
    i_pulse_enable_terminal <= 1'b1;
    i_failsafe_input <= i_failsafe_input + 1'b1;
    wr(`SFX_OFS_MODE, 32'h0);
    repeat (2) @(posedge i_mclk);
    chk_pin(o_sbc_armed, 1'b0, "brake off after exit");
    for (int i = 0; i < 12; i++) begin
      s0 = 8'($random(seed) & 3);
      s1 = ($random(seed) & 3) != 0 ? s0 : 8'($random(seed) & 3);
      b0 = 8'($random(seed) & 3);
      b1 = ($random(seed) & 3) != 0 ? b0 : 8'($random(seed) & 3);
      d0 = 16'($random(seed) & 3);
      d1 = ($random(seed) & 3) != 0 ? d0 : 16'($random(seed) & 3);
      t0 = 16'($random(seed) & 15);
      t1 = t0 + 16'($random(seed) & 3);
      check_case(s0, s1, b0, b1, d0, d1, t0, t1);
    end
    close_out();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    close_out();
  end

endmodule

`default_nettype wire
